// File: include/muldiv_params.svh
/*
  Timing counts, decode patterns and field positions for the multiply,
  divide, bit-probe and operand-match unit.
  Assumes a 125 MHz core clock and a host that includes this header by name.
*/
`ifndef MULDIV_PARAMS_SVH
`define MULDIV_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and machine cycle
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define MACHINE_CYCLE_NS 16

// Execution times in tenths of a machine cycle
`define T_MUL_SHORT_TENTHS 85
`define T_MUL_EXT_TENTHS 95
`define T_BIT_MISS_TENTHS 10
`define T_BIT_HIT_TENTHS 20
`define T_MATCH_MISS_TENTHS 30
`define T_MATCH_HIT_TENTHS 35

// Clock counts: tenths * cycle / (10 * period), at least one clock
`define TENTHS_TO_CLKS(t) \
  ((((t) * `MACHINE_CYCLE_NS) / (10 * `CLK_PERIOD_NS)) < 1 ? 1 : \
   (((t) * `MACHINE_CYCLE_NS) / (10 * `CLK_PERIOD_NS)))
`define CLKS_MUL_SHORT `TENTHS_TO_CLKS(`T_MUL_SHORT_TENTHS)
`define CLKS_MUL_EXT `TENTHS_TO_CLKS(`T_MUL_EXT_TENTHS)
`define CLKS_BIT_MISS `TENTHS_TO_CLKS(`T_BIT_MISS_TENTHS)
`define CLKS_BIT_HIT `TENTHS_TO_CLKS(`T_BIT_HIT_TENTHS)
`define CLKS_MATCH_MISS `TENTHS_TO_CLKS(`T_MATCH_MISS_TENTHS)
`define CLKS_MATCH_HIT `TENTHS_TO_CLKS(`T_MATCH_HIT_TENTHS)
`define CNT_W 8

// ----------------------------------------------------------------
// Opcode patterns (16-bit words)
// ----------------------------------------------------------------
`define OP_MUL_SHORT_HI 4'hE
`define OP_DIV_SHORT_HI 4'hF
`define OP_MUL_IMM 16'h0C70
`define OP_DIV_IMM 16'h0C78
`define OP_EXT_GROUP_HI 12'h0C7
`define OP_BIT_PROBE_HI 10'h034
`define OP_MATCH_HI 10'h036

// ----------------------------------------------------------------
// Field positions in the first word
// ----------------------------------------------------------------
`define F_DIVSEL_BIT 3
`define F_BIT_REG 5
`define F_BIT_VAL 4
`define F_BIT_IDX_HI 3
`define F_MATCH_REG 3

`endif

// File: include/muldiv_pkg.sv
/*
  Types shared by the execution unit, its checker and the bench models.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package muldiv_pkg;

  typedef enum logic [7:0] {
    OPK_NONE = 8'h01,
    OPK_MUL = 8'h02,
    OPK_DIV = 8'h04,
    OPK_MUL_EXT = 8'h08,
    OPK_DIV_EXT = 8'h10,
    OPK_BIT = 8'h20,
    OPK_MATCH = 8'h40,
    OPK_RSVD = 8'h80
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_DONE = 3'h4
  } state_t;

  typedef struct packed {
    logic start;
    logic [15:0] first_word;
    logic [15:0] second_word;
  } request_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] r;
  } operands_t;

  typedef struct packed {
    logic done;
    logic a_we;
    logic b_we;
    logic [15:0] a;
    logic [15:0] b;
    logic jump;
    logic [15:0] jump_addr;
    logic skip_two;
  } result_t;

endpackage

// File: hdl/signed_arith_core.sv
/*
  Signed 16x16 multiply and 32/16 divide, two's complement, combinational.
  Assumes the caller holds the operands stable until it samples the result.
*/
`timescale 1ns/10ps

module signed_arith_core (
  // Operands
  input wire logic [15:0] hi_in,
  input wire logic [15:0] lo_in,
  input wire logic [15:0] r_in,
  // Results
  output logic [15:0] prod_hi,
  output logic [15:0] prod_lo,
  output logic [15:0] quot,
  output logic [15:0] rem,
  output logic div_zero
);

  // ----------------------------------------------------------------
  // Multiply: multiplicand in the low word
  // ----------------------------------------------------------------
  wire logic signed [31:0] product;
  assign product = $signed(lo_in) * $signed(r_in);
  assign prod_hi = product[31:16];
  assign prod_lo = product[15:0];

  // ----------------------------------------------------------------
  // Divide: truncating, remainder takes the dividend sign
  // ----------------------------------------------------------------
  wire logic signed [31:0] dividend;
  wire logic signed [31:0] divisor;
  wire logic signed [31:0] q_full;
  wire logic signed [31:0] r_full;
  assign dividend = $signed({hi_in, lo_in});
  assign divisor = 32'(signed'(r_in));
  assign div_zero = (r_in == 16'h0000);
  assign q_full = div_zero ? 32'sh0000_0000 : dividend / divisor;
  assign r_full = div_zero ? dividend : dividend % divisor;
  assign quot = q_full[15:0];
  assign rem = r_full[15:0];

endmodule

// File: hdl/muldiv_bit_test_skip_unit.sv
/*
  Optional execution unit: signed multiply/divide in short, immediate and
  extended forms, bit-probe branch and skip on operand match.
  Assumes the host CPU on the same clock presents the instruction words and
  A, B, R values with start, holds them while busy, and applies the result
  on done. R is fetched by the host (immediate word or memory operand).
*/
`timescale 1ns/10ps
`include "muldiv_params.svh"

module muldiv_bit_test_skip_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Instruction from the host
  input wire muldiv_pkg::request_t req,
  input wire muldiv_pkg::operands_t opnd,
  // Status and results to the host
  output logic busy,
  output logic recognised,
  output muldiv_pkg::result_t res
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [15:0] w;
  wire logic is_mul_short;
  wire logic is_div_short;
  wire logic is_mul_imm;
  wire logic is_div_imm;
  wire logic is_ext_grp;
  wire logic is_mul_ext;
  wire logic is_div_ext;
  wire logic is_bit;
  wire logic is_match;
  wire muldiv_pkg::op_kind_t kind_dec;

  assign w = req.first_word;
  assign is_mul_short = (w[15:12] == `OP_MUL_SHORT_HI);
  assign is_div_short = (w[15:12] == `OP_DIV_SHORT_HI);
  assign is_mul_imm = (w == `OP_MUL_IMM);
  assign is_div_imm = (w == `OP_DIV_IMM);
  assign is_ext_grp = (w[15:4] == `OP_EXT_GROUP_HI) && (w[2:0] != 3'h0);
  assign is_mul_ext = is_ext_grp && !w[`F_DIVSEL_BIT];
  assign is_div_ext = is_ext_grp && w[`F_DIVSEL_BIT];
  assign is_bit = (w[15:6] == `OP_BIT_PROBE_HI);
  assign is_match = (w[15:6] == `OP_MATCH_HI);

  // Only six instruction kinds are claimed; anything else is left to the host
  assign kind_dec =
    (is_mul_short || is_mul_imm) ? muldiv_pkg::OPK_MUL :
    (is_div_short || is_div_imm) ? muldiv_pkg::OPK_DIV :
    is_mul_ext ? muldiv_pkg::OPK_MUL_EXT :
    is_div_ext ? muldiv_pkg::OPK_DIV_EXT :
    is_bit ? muldiv_pkg::OPK_BIT :
    is_match ? muldiv_pkg::OPK_MATCH : muldiv_pkg::OPK_NONE;
  assign recognised = (kind_dec != muldiv_pkg::OPK_NONE);

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  wire logic [15:0] probe_reg;
  wire logic probe_bit;
  wire logic probe_hit;
  wire logic [15:0] match_reg;
  wire logic match_hit;

  assign probe_reg = w[`F_BIT_REG] ? opnd.b : opnd.a;
  assign probe_bit = probe_reg[w[`F_BIT_IDX_HI:0]];
  assign probe_hit = (probe_bit == w[`F_BIT_VAL]);
  assign match_reg = w[`F_MATCH_REG] ? opnd.b : opnd.a;
  assign match_hit = (match_reg == opnd.r);

  // ----------------------------------------------------------------
  // Execution length per instruction
  // ----------------------------------------------------------------
  logic [`CNT_W-1:0] len_dec;
  always_comb begin
    case (kind_dec)
      muldiv_pkg::OPK_MUL, muldiv_pkg::OPK_DIV: begin
        len_dec = `CNT_W'(`CLKS_MUL_SHORT);
      end
      muldiv_pkg::OPK_MUL_EXT, muldiv_pkg::OPK_DIV_EXT: begin
        len_dec = `CNT_W'(`CLKS_MUL_EXT);
      end
      muldiv_pkg::OPK_BIT: begin
        len_dec = probe_hit ? `CNT_W'(`CLKS_BIT_HIT) : `CNT_W'(`CLKS_BIT_MISS);
      end
      muldiv_pkg::OPK_MATCH: begin
        len_dec = match_hit ? `CNT_W'(`CLKS_MATCH_HIT)
                            : `CNT_W'(`CLKS_MATCH_MISS);
      end
      default: begin
        len_dec = `CNT_W'(1);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Arithmetic core
  // ----------------------------------------------------------------
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic [15:0] r_q;
  wire logic [15:0] prod_hi;
  wire logic [15:0] prod_lo;
  wire logic [15:0] quot;
  wire logic [15:0] rem;

  signed_arith_core u_core (
    .hi_in(a_q),
    .lo_in(b_q),
    .r_in(r_q),
    .prod_hi(prod_hi),
    .prod_lo(prod_lo),
    .quot(quot),
    .rem(rem),
    .div_zero()
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  muldiv_pkg::state_t state_q;
  muldiv_pkg::state_t state_d;
  muldiv_pkg::op_kind_t kind_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [15:0] target_q;
  logic hit_q;
  wire logic accept;
  wire logic last;

  assign accept = (state_q == muldiv_pkg::ST_IDLE) && req.start && recognised;
  assign last = (state_q == muldiv_pkg::ST_EXEC) && (cnt_q == `CNT_W'(1));
  assign busy = (state_q != muldiv_pkg::ST_IDLE);

  always_comb begin
    case (state_q)
      muldiv_pkg::ST_IDLE: state_d = accept ? muldiv_pkg::ST_EXEC : muldiv_pkg::ST_IDLE;
      muldiv_pkg::ST_EXEC: state_d = last ? muldiv_pkg::ST_DONE : muldiv_pkg::ST_EXEC;
      muldiv_pkg::ST_DONE: state_d = muldiv_pkg::ST_IDLE;
      default: state_d = muldiv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= muldiv_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        cnt_q <= len_dec;
      end else if (state_q == muldiv_pkg::ST_EXEC) begin
        cnt_q <= cnt_q - `CNT_W'(1);
      end
    end
  end

  // Operand capture at acceptance
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      kind_q <= muldiv_pkg::OPK_NONE;
      a_q <= 16'h0000;
      b_q <= 16'h0000;
      r_q <= 16'h0000;
      target_q <= 16'h0000;
      hit_q <= 1'b0;
    end else if (accept) begin
      kind_q <= kind_dec;
      a_q <= opnd.a;
      b_q <= opnd.b;
      r_q <= opnd.r;
      target_q <= req.second_word;
      hit_q <= is_bit ? probe_hit : match_hit;
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  wire logic is_mul_k;
  wire logic is_div_k;
  assign is_mul_k = (kind_q == muldiv_pkg::OPK_MUL) || (kind_q == muldiv_pkg::OPK_MUL_EXT);
  assign is_div_k = (kind_q == muldiv_pkg::OPK_DIV) || (kind_q == muldiv_pkg::OPK_DIV_EXT);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res <= '0;
    end else if (last) begin
      res.done <= 1'b1;
      res.a_we <= is_mul_k || is_div_k;
      res.b_we <= is_mul_k || is_div_k;
      res.a <= is_div_k ? rem : prod_hi;
      res.b <= is_div_k ? quot : prod_lo;
      res.jump <= (kind_q == muldiv_pkg::OPK_BIT) && hit_q;
      res.jump_addr <= target_q;
      res.skip_two <= (kind_q == muldiv_pkg::OPK_MATCH) && hit_q;
    end else begin
      res.done <= 1'b0;
      res.a_we <= 1'b0;
      res.b_we <= 1'b0;
      res.jump <= 1'b0;
      res.skip_two <= 1'b0;
    end
  end

endmodule

// File: bench/muldiv_assertions.sv
/*
  Checker for the execution unit: decode, timing and results.
  Assumes binding to the ports of the unit's top module.
*/
`timescale 1ns/10ps

module muldiv_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Unit ports
  input wire muldiv_pkg::request_t req,
  input wire muldiv_pkg::operands_t opnd,
  input wire logic busy,
  input wire logic recognised,
  input wire muldiv_pkg::result_t res
);
  // ------
  // Decode
  // ------
  wire [15:0] fw = req.first_word;
  wire acc = req.start && !busy && recognised;
  wire d_short = fw[15:13] == 3'h7 || fw == 16'h0C70 || fw == 16'h0C78;
  wire d_ext = fw[15:4] == 12'h0C7 && fw[2:0] != 3'h0;
  wire d_bit = fw[15:6] == 10'h034;
  wire d_match = fw[15:6] == 10'h036;
  wire [15:0] sel = fw[5] ? opnd.b : opnd.a;
  wire hit = sel[fw[3:0]] == fw[4];
  wire eq = (fw[3] ? opnd.b : opnd.a) == opnd.r;
  wire is_mul = fw[15:12] == 4'hE || fw == 16'h0C70;
  wire signed [31:0] prod = $signed(opnd.b) * $signed(opnd.r);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_DECODE: assert property (recognised == (d_short || d_ext || d_bit || d_match))
    else $error("decode mismatch");
  AST_SHORT_TIME: assert property (acc && d_short |-> ##18 res.done)
    else $error("short form time wrong");
  AST_EXT_TIME: assert property (acc && d_ext |-> ##20 res.done)
    else $error("extended form time wrong");
  AST_BIT_HIT: assert property (acc && d_bit && hit |->
    ##5 res.done && res.jump)
    else $error("bit probe hit wrong");
  AST_BIT_MISS: assert property (acc && d_bit && !hit |-> ##3 res.done && !res.jump)
    else $error("bit probe miss wrong");
  AST_MATCH_EQ: assert property (acc && d_match && eq |-> ##8 res.done && res.skip_two)
    else $error("match equal wrong");
  AST_MATCH_NE: assert property (acc && d_match && !eq |->
    ##7 res.done && !res.skip_two)
    else $error("match differ wrong");
  AST_PRODUCT: assert property (acc && is_mul |->
    ##18 {res.a, res.b} == $past(prod, 18))
    else $error("product wrong");
  AST_DONE_PULSE: assert property (res.done |=> !res.done && !busy)
    else $error("done not a single pulse");
endmodule

// File: bench/host_cpu_model.sv
/*
  Host CPU stand-in: presents one instruction at a time, keeps A and B.
  Assumes the bench raises cmd.start for one clock per instruction.
*/
`timescale 1ns/10ps

module host_cpu_model (
  // Clock
  input wire logic clock,
  // Command from the bench
  input wire muldiv_pkg::request_t cmd,
  input wire muldiv_pkg::operands_t cmd_opnd,
  // Unit status and results
  input wire logic busy,
  input wire muldiv_pkg::result_t res,
  // Drive to the unit
  output muldiv_pkg::request_t req,
  output muldiv_pkg::operands_t opnd,
  // Host registers
  output logic [15:0] host_a,
  output logic [15:0] host_b
);
  initial begin
    req = '0;
    opnd = '0;
    host_a = '0;
    host_b = '0;
  end

  always @(posedge clock) begin
    req.start <= cmd.start && !busy;
    if (cmd.start && !busy) begin
      req.first_word <= cmd.first_word;
      req.second_word <= cmd.second_word;
      opnd <= cmd_opnd;
    end else if (res.done) begin
      // Operands no longer valid after completion
      opnd <= ~opnd;
    end
    if (res.a_we) host_a <= res.a;
    if (res.b_we) host_b <= res.b;
  end
endmodule

// File: bench/testbench.sv
/*
  Self-checking bench: arithmetic forms, bit probe, operand match, refusal.
  Assumes package, unit, host model and checker are compiled first.
*/
`timescale 1ns/10ps

module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  muldiv_pkg::request_t cmd = '0;
  muldiv_pkg::operands_t cmd_opnd = '0;
  muldiv_pkg::request_t req;
  muldiv_pkg::operands_t opnd;
  muldiv_pkg::result_t res;
  logic busy;
  logic recognised;
  logic [15:0] host_a;
  logic [15:0] host_b;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  always #4 clock = ~clock;

  host_cpu_model host_cpu_model_inst (.clock(clock), .cmd(cmd), .cmd_opnd(cmd_opnd),
    .busy(busy), .res(res), .req(req), .opnd(opnd), .host_a(host_a), .host_b(host_b));
  muldiv_bit_test_skip_unit muldiv_bit_test_skip_unit_inst (.clock(clock), .reset_n(reset_n),
    .req(req), .opnd(opnd), .busy(busy), .recognised(recognised), .res(res));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One instruction through the host, result captured in the done cycle
  task automatic issue(input logic [15:0] w1, w2, a, b, r, output muldiv_pkg::result_t got);
    cmd <= '{1'b1, w1, w2};
    cmd_opnd <= '{a, b, r};
    @(posedge clock);
    cmd.start <= 1'b0;
    for (int n = 0; n < 40 && res.done !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    got = res;
    @(posedge clock);
    #1;
  endtask

  task automatic t_arith;
    logic [15:0] fw [6] = '{16'hE123, 16'hF456, 16'h0C70, 16'h0C78, 16'h0C75, 16'h0C7F};
    logic [15:0] av [6] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h0000};
    logic [15:0] bv [6] = '{16'hFFC8, 16'hFB2E, 16'hFFC8, 16'hFB2E, 16'h8000, 16'h0007};
    logic [15:0] rv [6] = '{16'h04BC, 16'h0268, 16'h04BC, 16'h0268, 16'hFFFF, 16'hFFFE};
    logic signed [31:0] e;
    logic signed [31:0] dvd;
    logic signed [31:0] dvs;
    muldiv_pkg::result_t got;
    for (int i = 0; i < 6; i++) begin
      dvd = {av[i], bv[i]};
      dvs = {{16{rv[i][15]}}, rv[i]};
      e = $signed(bv[i]) * $signed(rv[i]);
      if (i % 2 == 1) e = {16'(dvd % dvs), 16'(dvd / dvs)};
      issue(fw[i], 16'h0000, av[i], bv[i], rv[i], got);
      chk(got.done, 1'b1);
      chk({host_a, host_b}, e);
    end
  endtask

  task automatic t_bit;
    muldiv_pkg::result_t got;
    logic [15:0] a0;
    logic [15:0] b0;
    a0 = host_a;
    b0 = host_b;
    issue(16'h0D10, 16'h1234, 16'h0001, 16'h0000, 16'h0000, got);
    chk({got.done, got.jump, got.jump_addr}, {2'h3, 16'h1234});
    issue(16'h0D23, 16'h4321, 16'h0000, 16'h003F, 16'h0000, got);
    chk({got.done, got.jump}, 2'h2);
    issue(16'h0D3F, 16'h00A5, 16'h0000, 16'h8000, 16'h0000, got);
    chk({got.jump, got.jump_addr}, {1'b1, 16'h00A5});
    chk(host_a, a0);
    chk(host_b, b0);
  endtask

  task automatic t_match;
    muldiv_pkg::result_t got;
    issue(16'h0D80, 16'h0000, 16'h1200, 16'h0000, 16'h1200, got);
    chk({got.done, got.skip_two}, 2'h3);
    issue(16'h0D88, 16'h0000, 16'h1200, 16'h1201, 16'h1200, got);
    chk({got.done, got.skip_two}, 2'h2);
  endtask

  task automatic t_refuse;
    logic [15:0] bad [3] = '{16'h0000, 16'h0D40, 16'h0C80};
    muldiv_pkg::result_t got;
    for (int i = 0; i < 3; i++) begin
      issue(bad[i], 16'h0000, 16'h0001, 16'h0002, 16'h0003, got);
      chk({got.done, busy, recognised}, 3'h0);
    end
  endtask

  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_arith;
    t_bit;
    t_match;
    t_refuse;
    finish_test;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      finish_test;
    end
  end
endmodule

bind muldiv_bit_test_skip_unit muldiv_assertions muldiv_assertions_inst (.clock(clock),
  .reset_n(reset_n), .req(req), .opnd(opnd), .busy(busy), .recognised(recognised), .res(res));
